// File: hw/rtc_flags_consts.vh
// constants for the clock flags and control register block
`ifndef RTC_FLAGS_CONSTS_VH
`define RTC_FLAGS_CONSTS_VH
// register byte addresses
`define ADDR_FLAGS      8'h00
`define ADDR_IRQ_STATUS 8'h04
`define ADDR_IRQ_MASK   8'h08
`define ADDR_CLOCK      8'h0c
`define ADDR_COUNTER    8'h10
// flag register bit positions
`define BIT_DOG   7
`define BIT_SUPPLY 5
`define BIT_TBLOST 4
`define BIT_TUNE  2
`define BIT_HOLD  1
`define BIT_SNAP  0
// interrupt status bit positions
`define IRQ_SUPPLY 0
`define IRQ_DOG    1
`define IRQ_TBLOST 2
`define IRQ_WIDTH  3
// reset values
`define FLAGS_RESET 8'h00
// timing: clock in kHz, start window in ms
`define MCLK_KHZ       125000
`define OSC_WINDOW_MS  5
`define OSC_WINDOW_CYC (`OSC_WINDOW_MS * `MCLK_KHZ)
`define TUNE_HZ        512
`define TUNE_HALF_CYC  ((`MCLK_KHZ * 1000) / (2 * `TUNE_HZ))
// axi response codes
`define RESP_OKAY   2'b00
`define RESP_SLVERR 2'b10
`endif

// File: hw/rtc_flags_ctrl.v
// clock flags and control register block with axi4-lite slave
// Summary of operation
// - supply loss flag sets when supply falls below trip level and clears on a flags read or power up.
// - at power up, an enabled oscillator not running within 5 ms sets the timebase lost flag.
// - the timebase lost flag is only cleared by software writing 0 to it or by power up.
// - with tuning mode set the alarm pin carries a 512 Hz square wave, else the interrupt.
// - tuning mode resets to 0 at power up.
// - writing 1 to the time set hold bit freezes clock register updates from the counters.
// - the clock register and the tuning and timebase lost flag bits accept writes only while the time set hold bit is 1.
// - clearing the hold bit after a time change loads the clock register into the counters.
// - the time set hold bit resets to 0 at power up.
// - dog timeout flag sets when the watchdog expires and clears on a flags read or power up.
//
// Implementation choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
`include "rtc_flags_consts.vh"
module rtc_flags_ctrl #(
	parameter [31:0] OSC_WINDOW = `OSC_WINDOW_CYC
) (
	input  wire        mclk,
	input  wire        rst,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        supply_low,
	input  wire        osc_enable,
	input  wire        osc_running,
	input  wire        dog_expired,
	input  wire [31:0] counter_value,
	output reg  [31:0] counter_load,
	output reg         counter_load_strobe,
	output reg         alarm_pin,
	output reg         irq
);
	wire supply_low_s;
	wire osc_running_s;
	wire osc_enable_s;
	wire dog_expired_s;
	reg  dog_prev;
	reg  supply_prev;

	// pin inputs into the clock domain
	sync2 u_sync_supply (.mclk(mclk), .rst(rst), .din(supply_low), .dout(supply_low_s));
	sync2 u_sync_osc (.mclk(mclk), .rst(rst), .din(osc_running), .dout(osc_running_s));
	sync2 u_sync_oen (.mclk(mclk), .rst(rst), .din(osc_enable), .dout(osc_enable_s));
	sync2 u_sync_dog (.mclk(mclk), .rst(rst), .din(dog_expired), .dout(dog_expired_s));

	reg        dog_timeout_flag;
	reg        supply_loss_flag;
	reg        timebase_lost_flag;
	reg        tune_mode;
	reg        time_set_hold;
	reg        snapshot_hold;
	reg        time_changed;
	reg [31:0] clock_reg;
	reg [31:0] holding_reg;
	reg [`IRQ_WIDTH-1:0] irq_status;
	reg [`IRQ_WIDTH-1:0] irq_mask;
	reg [31:0] osc_count;
	reg        osc_check_done;
	reg [16:0] tune_count;
	reg        tune_wave;

	// write channel latches
	reg        aw_held;
	reg        w_held;
	reg [7:0]  aw_addr;
	reg [31:0] w_data;
	reg [3:0]  w_strb;
	wire       do_write = aw_held && w_held && !s_axi_bvalid;
	wire       do_read  = s_axi_arvalid && s_axi_arready;
	wire       flags_read = do_read && (s_axi_araddr == `ADDR_FLAGS);
	wire       flags_wr = do_write && (aw_addr == `ADDR_FLAGS) && w_strb[0];
	// decoded register writes and terminal counts
	wire       clock_wr   = do_write && (aw_addr == `ADDR_CLOCK);
	wire       mask_wr    = do_write && (aw_addr == `ADDR_IRQ_MASK);
	wire       status_wr  = do_write && (aw_addr == `ADDR_IRQ_STATUS);
	wire       tb_clear   = flags_wr && time_set_hold && !w_data[`BIT_TBLOST];
	wire       base_load  = flags_wr && time_set_hold && !w_data[`BIT_HOLD] && time_changed;
	wire       tune_last  = (tune_count == `TUNE_HALF_CYC - 1);
	wire       dog_event = dog_expired_s && !dog_prev;
	wire       supply_event = supply_low_s && !supply_prev;
	wire       osc_fail_event = !osc_check_done && (osc_count == OSC_WINDOW - 32'd1)
	                            && osc_enable_s && !osc_running_s;
	wire       addr_ok = (aw_addr == `ADDR_FLAGS) || (aw_addr == `ADDR_IRQ_STATUS) ||
	                     (aw_addr == `ADDR_IRQ_MASK) || (aw_addr == `ADDR_CLOCK) ||
	                     (aw_addr == `ADDR_COUNTER);
	wire [7:0] flags_value = {dog_timeout_flag, 1'b0, supply_loss_flag, timebase_lost_flag,
	                          1'b0, tune_mode, time_set_hold, snapshot_hold};
	reg  [31:0] next_rdata;
	reg         next_rok;

	// write address and data handshakes, either order
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			aw_addr       <= 8'h00;
			w_data        <= 32'h00000000;
			w_strb        <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
			s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= addr_ok ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// read data mux
	always @* begin
		next_rdata = 32'h00000000;
		next_rok   = 1'b1;
		case (s_axi_araddr)
			`ADDR_FLAGS:      next_rdata = {24'h000000, flags_value};
			`ADDR_IRQ_STATUS: next_rdata = {29'h00000000, irq_status};
			`ADDR_IRQ_MASK:   next_rdata = {29'h00000000, irq_mask};
			`ADDR_CLOCK:      next_rdata = clock_reg;
			`ADDR_COUNTER:    next_rdata = holding_reg;
			default:          next_rok   = 1'b0;
		endcase
	end

	// read channel
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `RESP_OKAY;
		end else begin
			s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
			if (do_read) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= next_rdata;
				s_axi_rresp  <= next_rok ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// oscillator start check over the first window after reset
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			osc_count      <= 32'h00000000;
			osc_check_done <= 1'b0;
		end else if (!osc_check_done) begin
			osc_count <= osc_count + 32'd1;
			if (osc_count == OSC_WINDOW - 32'd1)
				osc_check_done <= 1'b1;
		end
	end

	// edge detectors for the synchronised event pins
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			dog_prev    <= 1'b0;
			supply_prev <= 1'b0;
		end else begin
			dog_prev    <= dog_expired_s;
			supply_prev <= supply_low_s;
		end
	end

	// supply loss flag; a set in the same cycle as a clear wins
	always @(posedge mclk or posedge rst) begin
		if (rst)
			supply_loss_flag <= 1'b0;
		else if (supply_event)
			supply_loss_flag <= 1'b1;
		else if (flags_read)
			supply_loss_flag <= 1'b0;
	end

	// dog timeout flag; a set in the same cycle as a clear wins
	always @(posedge mclk or posedge rst) begin
		if (rst)
			dog_timeout_flag <= 1'b0;
		else if (dog_event)
			dog_timeout_flag <= 1'b1;
		else if (flags_read)
			dog_timeout_flag <= 1'b0;
	end

	// timebase lost flag; only a software write of 0 or reset clears it
	always @(posedge mclk or posedge rst) begin
		if (rst)
			timebase_lost_flag <= 1'b0;
		else if (osc_fail_event)
			timebase_lost_flag <= 1'b1;
		else if (tb_clear)
			timebase_lost_flag <= 1'b0;
	end

	// control bits, clock register and base time transfer
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			tune_mode           <= 1'b0;
			time_set_hold       <= 1'b0;
			snapshot_hold       <= 1'b0;
			time_changed        <= 1'b0;
			clock_reg           <= 32'h00000000;
			counter_load        <= 32'h00000000;
			counter_load_strobe <= 1'b0;
			irq_mask            <= 3'b000;
		end else begin
			counter_load_strobe <= 1'b0;
			if (!time_set_hold)
				clock_reg <= counter_value;
			if (flags_wr) begin
				time_set_hold <= w_data[`BIT_HOLD];
				snapshot_hold <= w_data[`BIT_SNAP];
				if (time_set_hold)
					tune_mode <= w_data[`BIT_TUNE];
			end
			if (base_load) begin
				counter_load        <= clock_reg;
				counter_load_strobe <= 1'b1;
				time_changed        <= 1'b0;
			end
			if (clock_wr && time_set_hold) begin
				clock_reg    <= w_data;
				time_changed <= 1'b1;
			end
			if (mask_wr)
				irq_mask <= w_data[`IRQ_WIDTH-1:0];
		end
	end

	// holding register for stable reads
	always @(posedge mclk or posedge rst) begin
		if (rst)
			holding_reg <= 32'h00000000;
		else if (!snapshot_hold)
			holding_reg <= counter_value;
	end

	// sticky interrupt status, write one to clear, set wins
	always @(posedge mclk or posedge rst) begin
		if (rst)
			irq_status <= 3'b000;
		else
			irq_status <= (irq_status & ~(status_wr ? w_data[`IRQ_WIDTH-1:0] : 3'b000))
			              | {osc_fail_event, dog_event, supply_event};
	end

	// interrupt level, high while an unmasked status bit is set
	always @(posedge mclk or posedge rst) begin
		if (rst)
			irq <= 1'b0;
		else
			irq <= |(irq_status & irq_mask);
	end

	// 512 Hz square wave or interrupt on the alarm pin
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			tune_count <= 17'h00000;
			tune_wave  <= 1'b0;
			alarm_pin  <= 1'b0;
		end else begin
			if (!tune_mode || tune_last) begin
				tune_count <= 17'h00000;
				tune_wave  <= tune_mode ? !tune_wave : 1'b0;
			end else begin
				tune_count <= tune_count + 17'd1;
			end
			alarm_pin <= tune_mode ? tune_wave : |(irq_status & irq_mask);
		end
	end
endmodule // rtc_flags_ctrl
`default_nettype wire

// File: hw/sync2.v
// two flip-flop level synchroniser
`timescale 1ns/1ns
`default_nettype none
module sync2 (
	input  wire mclk,
	input  wire rst,
	input  wire din,
	output reg  dout
);
	reg stage1;

	// first stage feeds only the second
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			stage1 <= 1'b0;
			dout   <= 1'b0;
		end else begin
			stage1 <= din;
			dout   <= stage1;
		end
	end
endmodule // sync2
`default_nettype wire

// File: testbench/rtc_flags_ctrl_asserts.sv
// checker for the clock flags register block
`timescale 1ns/1ns
`default_nettype none
module rtc_flags_ctrl_asserts #(
	parameter [31:0] OSC_WINDOW = 32'h14
) (
	input wire logic        mclk,
	input wire logic        rst,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        counter_load_strobe,
	input wire logic        alarm_pin,
	input wire logic        irq
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	// read request taken, then answer pending
	sequence s_rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence s_rd_wait;
		s_axi_rvalid && !s_axi_rready;
	endsequence
	// load strobe, reset outputs, write and read handshake relations
	a_load_one_cycle: assert property (counter_load_strobe |=> !counter_load_strobe)
		else $error("load strobe longer than one cycle");
	a_reset_quiet: assert property ($fell(rst) |-> !irq && !alarm_pin && !counter_load_strobe)
		else $error("outputs active after reset");
	a_wready_pulse: assert property (s_axi_wready |=> !s_axi_wready)
		else $error("write ready longer than one cycle");
	a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	a_read_answer: assert property (s_rd_take |=> s_axi_rvalid)
		else $error("read answer late");
	a_rvalid_hold: assert property (s_rd_wait |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data changed while pending");
	a_error_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
		else $error("error read returned data");
	a_no_early_read: assert property (!s_axi_rvalid && !s_axi_arready |=> !s_axi_rvalid)
		else $error("read answer without request");
endmodule // rtc_flags_ctrl_asserts
bind rtc_flags_ctrl rtc_flags_ctrl_asserts #(.OSC_WINDOW(OSC_WINDOW)) i_chk (.mclk, .rst, .s_axi_wready,
	.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
	.s_axi_rvalid, .s_axi_rready, .counter_load_strobe, .alarm_pin, .irq);
`default_nettype wire

// File: testbench/rtc_flags_ctrl_bench.sv
// self-checking bench for the clock flags register block
`timescale 1ns/1ns
`default_nettype none
module rtc_flags_ctrl_bench;
	logic	mclk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic	s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, supply_low, osc_enable, osc_running;
	logic	dog_expired, counter_load_strobe, alarm_pin, irq;
	logic [7:0]	s_axi_awaddr, s_axi_araddr;
	logic [3:0]	s_axi_wstrb;
	logic [1:0]	s_axi_bresp, s_axi_rresp, r;
	logic [31:0]	s_axi_wdata, s_axi_rdata, counter_value, counter_load, q, last_load, loads;
	int	err_total, checks_done;
	bit	slow;
	typedef struct {bit wr; logic [7:0] a; logic [31:0] v; logic [1:0] rs;} row_t;
	// op, address, write data or read expectation, response
	row_t rows[17] = '{'{1'h0, 8'h0c, 32'hab, 2'h0}, '{1'h1, 8'h00, 32'h0, 2'h0}, '{1'h0, 8'h00, 32'h10, 2'h0},
		'{1'h1, 8'h00, 32'h2, 2'h0}, '{1'h0, 8'h00, 32'h12, 2'h0}, '{1'h1, 8'h00, 32'h6, 2'h0},
		'{1'h0, 8'h00, 32'h6, 2'h0}, '{1'h1, 8'h00, 32'h2, 2'h0}, '{1'h0, 8'h00, 32'h2, 2'h0},
		'{1'h1, 8'h0c, 32'h12345678, 2'h0}, '{1'h0, 8'h0c, 32'h12345678, 2'h0}, '{1'h0, 8'h14, 32'h0, 2'h2},
		'{1'h1, 8'h14, 32'h0, 2'h2}, '{1'h1, 8'h08, 32'h7, 2'h0}, '{1'h0, 8'h08, 32'h7, 2'h0},
		'{1'h1, 8'h04, 32'h7, 2'h0}, '{1'h0, 8'h04, 32'h0, 2'h0}};

	rtc_flags_ctrl #(.OSC_WINDOW(32'h14)) i_dut (.mclk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.supply_low, .osc_enable, .osc_running, .dog_expired, .counter_value, .counter_load,
		.counter_load_strobe, .alarm_pin, .irq);

	// 8 ns clock
	initial begin
		mclk = 1'h0;
		forever #4 mclk = ~mclk;
	end

	// count base time loads
	always @(posedge mclk) begin
		if (counter_load_strobe === 1'h1) begin
			loads <= loads + 32'h1;
			last_load <= counter_load;
		end
	end

	task give_verdict;
		$display("errors %0d checks %0d", err_total, checks_done);
		if (err_total == 0 && checks_done > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	task chk_word(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
		end
	endtask

	task chk_bit(input logic g, input logic e);
		chk_word({31'h0, g}, {31'h0, e});
	endtask

	// one bus transfer, write or read, released once answered
	task xfer(input bit wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= wr;
		s_axi_wvalid <= wr;
		s_axi_bready <= wr && !slow;
		s_axi_arvalid <= !wr;
		s_axi_rready <= !wr && !slow;
		do begin
			@(posedge mclk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
			if (slow && n == 4) begin
				s_axi_bready <= wr;
				s_axi_rready <= !wr;
			end
		end while (!(wr ? s_axi_bvalid && s_axi_bready : s_axi_rvalid && s_axi_rready) && n < 60);
		r = wr ? s_axi_bresp : s_axi_rresp;
		q = s_axi_rdata;
		s_axi_bready <= 1'h0;
		s_axi_rready <= 1'h0;
		@(posedge mclk);
		if (n >= 60) begin
			chk_bit(1'h0, 1'h1);
			give_verdict;
		end
	endtask

	initial begin
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, supply_low, dog_expired, osc_running} = 51'h0;
		{rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h20;
		{err_total, checks_done, loads, last_load} = 128'h0;
		s_axi_wstrb = 4'hf;
		osc_enable = 1'h1;
		counter_value = 32'hab;
		repeat (10) @(posedge mclk);
		rst <= 1'h0;
		repeat (30) @(posedge mclk);
		foreach (rows[i]) begin
			xfer(rows[i].wr, rows[i].a, rows[i].v);
			chk_word({30'h0, r}, {30'h0, rows[i].rs});
			if (!rows[i].wr) chk_word(q, rows[i].v);
		end
		// frozen clock register, then base time load on release
		counter_value <= 32'hcd;
		repeat (3) @(posedge mclk);
		xfer(1'h0, 8'h0c, 32'h0);
		chk_word(q, 32'h12345678);
		xfer(1'h1, 8'h00, 32'h0);
		xfer(1'h0, 8'h0c, 32'h0);
		chk_word(q, 32'hcd);
		chk_word(loads, 32'h1);
		chk_word(last_load, 32'h12345678);
		// snapshot hold keeps the holding register still
		xfer(1'h1, 8'h00, 32'h1);
		counter_value <= 32'hee;
		xfer(1'h0, 8'h10, 32'h0);
		chk_word(q, 32'hcd);
		xfer(1'h1, 8'h00, 32'h0);
		xfer(1'h0, 8'h10, 32'h0);
		chk_word(q, 32'hee);
		// supply and watchdog events, interrupt mask and clear
		supply_low <= 1'h1;
		dog_expired <= 1'h1;
		repeat (6) @(posedge mclk);
		supply_low <= 1'h0;
		dog_expired <= 1'h0;
		chk_bit(irq, 1'h1);
		chk_bit(alarm_pin, 1'h1);
		xfer(1'h0, 8'h00, 32'h0);
		chk_word(q, 32'ha0);
		xfer(1'h0, 8'h00, 32'h0);
		chk_word(q, 32'h0);
		xfer(1'h1, 8'h08, 32'h0);
		chk_bit(irq, 1'h0);
		xfer(1'h1, 8'h08, 32'h7);
		chk_bit(irq, 1'h1);
		xfer(1'h1, 8'h04, 32'h3);
		chk_bit(irq, 1'h0);
		// mid-run power up with tuning and hold set, then late ready on both channels
		xfer(1'h1, 8'h00, 32'h2);
		xfer(1'h1, 8'h00, 32'h6);
		osc_running <= 1'h1;
		rst <= 1'h1;
		repeat (3) @(posedge mclk);
		rst <= 1'h0;
		repeat (30) @(posedge mclk);
		chk_bit(alarm_pin, 1'h0);
		slow = 1'h1;
		xfer(1'h0, 8'h00, 32'h0);
		chk_word(q, 32'h0);
		xfer(1'h1, 8'h08, 32'h5);
		chk_word({30'h0, r}, 32'h0);
		xfer(1'h0, 8'h08, 32'h0);
		chk_word(q, 32'h5);
		give_verdict;
	end
endmodule // rtc_flags_ctrl_bench
`default_nettype wire
